// ### spfe_front_end.v
// Serial command front end of an 8K x 8 memory, plus its write stream FIFO.
// Assumes a 40 MHz CLK far faster than the link clock; memory array sits
// outside: reads answer MEM_RD_DATA one CLK after MEM_RD_ADDR, writes drain
// through the FIFO on a valid/ready handshake.
//
// Behaviour
// [R1] Deselected: serial input ignored, serial output high impedance.
// [R2] One opcode per select period; new command needs a new select.
// [R3] Input sampled on rising link clock, output changed on falling.
// [R4] All bytes travel most significant bit first.
// [R5] Two address bytes; only low 13 bits used, top three dropped.
// [R6] Master should send the three unused address bits as zero.
// [R7] First full byte after select is the opcode.
// [R8] Unknown opcode: ignore input until next select, output stays off.
// [R9] Clock level at select picks mode 0 (low) or mode 3 (high).
// [R10] Mode 3: first bit taken on rising edge after first toggle.
// [R11] Master parks clock low in mode 0, high in mode 3.
// [R12] Master waits the power up interval before first select.
// [R13] Decode set-latch and clear-latch opcodes.
// [R14] Decode read-status and write-status opcodes.
// [R15] Decode memory read and memory write opcodes.
// [R16] Latch clear at power up; writes without it have no effect.
// [R17] Set-latch opcode sets latch, shown in status bit 1.
// [R18] Status write never changes the latch bit.
// [R19] Latch clears at deselect after clear-latch, status or memory write.
// [R20] Status: bit 7 pin protect, bits 3..2 block protect, bit 1 latch.
// [R21] Block protect 01 upper quarter, 10 upper half, 11 all, 00 none.
// [R22] Status write refused only when pin protect set and pin low.
// [R23] Burst address increments per byte, wraps top to zero.
// [R24] Output driven only while returning status or memory data.
`timescale 1ns/1ps
`include "spfe_map.vh"

module spfe_fifo #(
	parameter WIDTH = 21,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk, // System clock
	input wire rst, // Synchronous reset, active high
	input wire in_valid, // Source offers a word
	output wire in_ready, // Room for a word
	input wire [WIDTH-1:0] in_data, // Word in
	output wire out_valid, // A word waits
	input wire out_ready, // Sink takes the word
	output wire [WIDTH-1:0] out_data // Oldest word
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	// Full and empty come straight from the occupancy count
	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage is written without reset; only pointers and count need defined state
	always @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap naturally since depth is a power of two
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

module spfe_front_end (
	input wire CLK, // 40 MHz system clock
	input wire RST, // Synchronous reset, active high (power-on reset)
	input wire CS_N, // Chip select pin, active low
	input wire SCK, // Link clock pin from the master
	input wire SI, // Serial data in
	input wire WP_N, // Write protect pin, active low
	output reg SO, // Serial data out
	output reg SO_OE_N, // Serial out enable, low while driving
	output reg [12:0] MEM_RD_ADDR, // Memory read address
	input wire [7:0] MEM_RD_DATA, // Read data, valid one CLK after address
	output wire MEM_WR_VALID, // Write word waiting
	input wire MEM_WR_READY, // Memory takes the write word
	output wire [20:0] MEM_WR_WORD, // {address, data} of the write
	output reg [7:0] PROT_STATUS // Live protection status byte
);
	localparam ST_IDLE = 3'd0;
	localparam ST_OPC = 3'd1;
	localparam ST_ADDR = 3'd2;
	localparam ST_RSTAT = 3'd3;
	localparam ST_WSTAT = 3'd4;
	localparam ST_RMEM = 3'd5;
	localparam ST_WMEM = 3'd6;
	localparam ST_IGNORE = 3'd7;

	reg cs_s1_q, cs_s2_q, cs_s3_q;
	reg sck_s1_q, sck_s2_q, sck_s3_q;
	reg si_s1_q, si_s2_q;
	reg wp_s1_q, wp_s2_q;
	reg [2:0] state_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg armed_q;
	reg addr_byte_q;
	reg is_write_q;
	reg clr_latch_q;
	reg load_rd_q;
	reg latch_q;
	reg pin_protect_q;
	reg [1:0] bp_q;
	reg [12:0] addr_q;
	reg [20:0] pend_word_q;
	reg pend_q;
	wire cs_fall;
	wire cs_rise;
	wire sck_rise;
	wire sck_fall;
	wire byte_done;
	wire [7:0] byte_in;
	wire [7:0] status;
	wire addr_prot;
	wire fifo_ready;

	// [R1] Pin synchronisers
	// Two flops on SI and WP_N, three on CS_N and SCK; edge detectors read only the second and third
	always @(posedge CLK) begin
		if (RST) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= CS_N;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			sck_s1_q <= SCK;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= SI;
			si_s2_q <= si_s1_q;
			wp_s1_q <= WP_N;
			wp_s2_q <= wp_s1_q;
		end
	end

	// [R3] Edge finders
	assign cs_fall = cs_s3_q && !cs_s2_q;
	assign cs_rise = !cs_s3_q && cs_s2_q;
	assign sck_rise = !sck_s3_q && sck_s2_q && !cs_s2_q && armed_q;
	assign sck_fall = sck_s3_q && !sck_s2_q && !cs_s2_q;

	// [R4] MSB first assembly
	assign byte_in = {shift_q[6:0], si_s2_q};
	assign byte_done = sck_rise && (bit_cnt_q == 3'd7);

	// [R20] Status byte, fixed bits zero
	assign status = {pin_protect_q, 3'b000, bp_q, latch_q, 1'b0};

	// [R21] Block protect ranges
	assign addr_prot = (bp_q == 2'b11) ||
		(bp_q == 2'b10 && addr_q >= `SPFE_PROT_HALF) ||
		(bp_q == 2'b01 && addr_q >= `SPFE_PROT_QUARTER);

	// Writes queue here so a sink pause loses none until the FIFO is full with a word still pending
	spfe_fifo #(
		.WIDTH(`SPFE_FIFO_W),
		.DEPTH(`SPFE_FIFO_DEPTH),
		.AW(`SPFE_FIFO_AW)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(pend_q),
		.in_ready(fifo_ready),
		.in_data(pend_word_q),
		.out_valid(MEM_WR_VALID),
		.out_ready(MEM_WR_READY),
		.out_data(MEM_WR_WORD)
	);

	// Bit framing and mode arming
	// [R9] Clock level at select picks the mode; mode 3 arms on first fall
	always @(posedge CLK) begin
		if (RST) begin
			armed_q <= 1'b0;
			bit_cnt_q <= 3'd0;
			shift_q <= 8'h00;
		end else if (cs_fall) begin
			armed_q <= !sck_s2_q;
			bit_cnt_q <= 3'd0;
			shift_q <= 8'h00;
		end else begin
			// [R10] Mode 3 skips the idle-high level
			if (sck_fall) begin
				armed_q <= 1'b1;
			end
			if (sck_rise) begin
				shift_q <= byte_in;
				bit_cnt_q <= bit_cnt_q + 3'd1;
			end
		end
	end

	// Command sequencer
	always @(posedge CLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
			addr_byte_q <= 1'b0;
			is_write_q <= 1'b0;
			clr_latch_q <= 1'b0;
			load_rd_q <= 1'b0;
			latch_q <= 1'b0;
			pin_protect_q <= 1'b0;
			bp_q <= 2'b00;
			addr_q <= 13'h0000;
			pend_q <= 1'b0;
			pend_word_q <= 21'h00_0000;
			tx_q <= 8'h00;
			MEM_RD_ADDR <= 13'h0000;
		end else begin
			load_rd_q <= 1'b0;
			// Pending write leaves once the FIFO has room
			if (pend_q && fifo_ready) begin
				pend_q <= 1'b0;
			end
			// One cycle after the address the memory answers
			if (load_rd_q) begin
				tx_q <= MEM_RD_DATA;
			end
			if (cs_rise) begin
				// [R19] Latch clears at deselect after write-type commands
				if (clr_latch_q) begin
					latch_q <= 1'b0;
				end
				clr_latch_q <= 1'b0;
				state_q <= ST_IDLE;
			end else if (cs_fall) begin
				// [R2] Each select opens exactly one command
				state_q <= ST_OPC;
				addr_byte_q <= 1'b0;
			end else if (sck_fall && (state_q == ST_RSTAT || state_q == ST_RMEM)) begin
				// [R3] Shift out on falling edges
				tx_q <= {tx_q[6:0], 1'b0};
			end else if (byte_done) begin
				case (state_q)
				// [R7] First byte is the opcode
				ST_OPC: begin
					case (byte_in)
					// [R13] Latch opcodes
					`SPFE_OP_SET_WRITE_LATCH: begin
						// [R17] Latch set at once
						latch_q <= 1'b1;
						state_q <= ST_IGNORE;
					end
					`SPFE_OP_CLEAR_WRITE_LATCH: begin
						clr_latch_q <= 1'b1;
						state_q <= ST_IGNORE;
					end
					// [R14] Status opcodes
					`SPFE_OP_READ_STATUS: begin
						tx_q <= status;
						state_q <= ST_RSTAT;
					end
					`SPFE_OP_WRITE_STATUS: begin
						clr_latch_q <= 1'b1;
						state_q <= ST_WSTAT;
					end
					// [R15] Memory opcodes
					`SPFE_OP_READ_MEM: begin
						is_write_q <= 1'b0;
						state_q <= ST_ADDR;
					end
					`SPFE_OP_WRITE_MEM: begin
						is_write_q <= 1'b1;
						clr_latch_q <= 1'b1;
						state_q <= ST_ADDR;
					end
					// [R8] Unknown opcode waits for the next select
					default: begin
						state_q <= ST_IGNORE;
					end
					endcase
				end
				ST_ADDR: begin
					// [R5] Top three address bits dropped
					if (!addr_byte_q) begin
						addr_q[12:8] <= byte_in[4:0];
						addr_byte_q <= 1'b1;
					end else begin
						addr_q[7:0] <= byte_in;
						if (is_write_q) begin
							state_q <= ST_WMEM;
						end else begin
							MEM_RD_ADDR <= {addr_q[12:8], byte_in};
							addr_q <= {addr_q[12:8], byte_in} + 13'h0001;
							load_rd_q <= 1'b1;
							state_q <= ST_RMEM;
						end
					end
				end
				ST_RSTAT: begin
					// Repeats the live status while clocks continue
					tx_q <= status;
				end
				ST_WSTAT: begin
					// [R22] Refused only with pin protect on and pin low
					// [R16] No effect without the latch
					if (latch_q && !(pin_protect_q && !wp_s2_q)) begin
						// [R18] Latch bit is never written here
						pin_protect_q <= byte_in[`SPFE_STAT_PIN_PROTECT];
						bp_q <= byte_in[`SPFE_STAT_BP_HIGH:`SPFE_STAT_BP_LOW];
					end
					state_q <= ST_IGNORE;
				end
				ST_RMEM: begin
					// [R23] Read burst wraps at the top
					MEM_RD_ADDR <= addr_q;
					addr_q <= addr_q + 13'h0001;
					load_rd_q <= 1'b1;
				end
				ST_WMEM: begin
					// [R16] [R21] Latch off or protected block ends the burst
					if (!latch_q || addr_prot) begin
						state_q <= ST_IGNORE;
					end else begin
						// A byte landing while one still waits and the FIFO is full is dropped
						if (!pend_q || fifo_ready) begin
							pend_q <= 1'b1;
							pend_word_q <= {addr_q, byte_in};
						end
						// [R23] Wraps from the top address to zero
						addr_q <= addr_q + 13'h0001;
					end
				end
				default: begin
					state_q <= state_q;
				end
				endcase
			end
		end
	end

	// Serial output and its enable
	// [R24] Driven only in the read phases, after the first falling edge
	// [R1] Released as soon as select is seen high
	always @(posedge CLK) begin
		if (RST) begin
			SO <= 1'b0;
			SO_OE_N <= 1'b1;
			PROT_STATUS <= `SPFE_STAT_RESET;
		end else begin
			PROT_STATUS <= status;
			if (cs_s2_q || !(state_q == ST_RSTAT || state_q == ST_RMEM)) begin
				SO_OE_N <= 1'b1;
			end else if (sck_fall) begin
				// [R4] MSB leaves first
				SO <= tx_q[7];
				SO_OE_N <= 1'b0;
			end
		end
	end
endmodule

// ### spfe_front_end_assertions.sv
// Port checker for the serial front end, bound to its top module.
// Assumes CS_N and WP_N only change while no command is in flight.
`timescale 1ns/1ps
`include "spfe_map.vh"
module spfe_front_end_chk (
	input wire CLK, // System clock
	input wire RST, // Synchronous reset
	input wire CS_N, // Chip select
	input wire WP_N, // Write protect pin
	input wire SO_OE_N, // Serial out enable
	input wire MEM_WR_VALID, // Write word waiting
	input wire [20:0] MEM_WR_WORD, // Write word
	input wire [7:0] PROT_STATUS // Status copy
);
	wire [12:0] wa = MEM_WR_WORD[20:8];
	// Address falls inside the block protected range
	wire hit = PROT_STATUS[3] ? (PROT_STATUS[2] || wa >= `SPFE_PROT_HALF) :
		(PROT_STATUS[2] && wa >= `SPFE_PROT_QUARTER);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	chk_idle_output_off: assert property (CS_N [*8] |-> SO_OE_N)
		else $error("serial out driven while deselected");
	chk_reset_clean: assert property ($fell(RST) |->
		SO_OE_N && !MEM_WR_VALID && PROT_STATUS == 8'h00)
		else $error("outputs not clean after reset");
	chk_fixed_zero_bits: assert property (PROT_STATUS[6:4] == 3'h0 && !PROT_STATUS[0])
		else $error("fixed status bits not zero");
	chk_latch_set_sel: assert property ($rose(PROT_STATUS[1]) |-> !CS_N && !$past(CS_N, 2))
		else $error("latch set outside a command");
	chk_latch_clear_desel: assert property ($fell(PROT_STATUS[1]) |-> CS_N)
		else $error("latch cleared before deselect");
	chk_status_pin_locked: assert property ((PROT_STATUS[7] && !WP_N) |=>
		PROT_STATUS[7:2] == $past(PROT_STATUS[7:2]))
		else $error("status changed while pin locked");
	chk_write_needs_latch: assert property ($rose(MEM_WR_VALID) |-> PROT_STATUS[1])
		else $error("memory write without latch");
	chk_write_unprot_addr: assert property ($rose(MEM_WR_VALID) |-> !hit)
		else $error("write into protected block");
	chk_drive_in_sel: assert property ($fell(SO_OE_N) |-> !CS_N)
		else $error("output enabled without select");
endmodule
bind spfe_front_end spfe_front_end_chk spfe_front_end_chk_inst (.CLK(CLK), .RST(RST),
	.CS_N(CS_N), .WP_N(WP_N), .SO_OE_N(SO_OE_N), .MEM_WR_VALID(MEM_WR_VALID),
	.MEM_WR_WORD(MEM_WR_WORD), .PROT_STATUS(PROT_STATUS));

// ### spfe_front_end_tb.sv
// Self-checking bench: command sequences through the master model.
// Assumes the checker is bound; memory answers one CLK after the address.
`timescale 1ns/1ps
module spfe_front_end_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg ready;
	reg wp_n;
	wire [7:0] rd_data;
	reg [7:0] s;
	reg [7:0] q;
	integer error_cnt = 0;
	integer checks = 0;
	integer k;
	wire cs_n, sck, si, so, so_oe_n, valid;
	wire [12:0] rd_addr;
	wire [20:0] word;
	wire [7:0] stat;
	spfe_front_end spfe_front_end_inst (.CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck),
		.SI(si), .WP_N(wp_n), .SO(so), .SO_OE_N(so_oe_n), .MEM_RD_ADDR(rd_addr),
		.MEM_RD_DATA(rd_data), .MEM_WR_VALID(valid), .MEM_WR_READY(ready),
		.MEM_WR_WORD(word), .PROT_STATUS(stat));
	spfe_spi_master spfe_spi_master_inst (.clk(clk), .so(so), .so_oe_n(so_oe_n),
		.cs_n(cs_n), .sck(sck), .si(si));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Array stand-in: data is a fixed pattern of the address, ready the
	// cycle after the address changes, as the front end expects
	assign rd_data = rd_addr[7:0] ^ 8'h3C;
	task report_and_stop;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task cmp_byte(input [7:0] got, input [7:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task cmp_word(input [20:0] got, input [20:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task cmd(input [7:0] op);
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(op, q);
		spfe_spi_master_inst.desel;
	endtask
	// Status read uses mode 3 so both clock modes get exercised
	task rd_stat(input [7:0] exp);
		spfe_spi_master_inst.sel(1'b1);
		spfe_spi_master_inst.xfer(8'h05, q);
		spfe_spi_master_inst.xfer(8'h00, s);
		spfe_spi_master_inst.desel;
		cmp_byte(s, exp);
	endtask
	task wr_stat(input [7:0] v);
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(8'h01, q);
		spfe_spi_master_inst.xfer(v, q);
		spfe_spi_master_inst.desel;
	endtask
	// Pop n words one by one, bounded wait per word
	task drain(input [12:0] a, input [7:0] d, input integer n);
		integer j, w;
		for (j = 0; j < n; j = j + 1) begin
			w = 0;
			while (valid !== 1'b1 && w < 50) begin
				@(posedge clk);
				w = w + 1;
			end
			if (w == 50) begin
				error_cnt = error_cnt + 1;
				report_and_stop;
			end
			cmp_word(word, {a + j[12:0], d + j[7:0]});
			ready <= 1'b1;
			@(posedge clk);
			ready <= 1'b0;
			@(posedge clk);
		end
		cmp_byte({7'h00, valid}, 8'h00);
	endtask
	initial begin
		ready <= 1'b0;
		wp_n <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		rd_stat(8'h00);
		wr_stat(8'h8C);
		rd_stat(8'h00);
		cmd(8'h06);
		rd_stat(8'h02);
		cmd(8'h04);
		rd_stat(8'h00);
		// Second opcode inside one select must be ignored: the latch stays set
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(8'h06, q);
		spfe_spi_master_inst.xfer(8'h04, q);
		spfe_spi_master_inst.desel;
		rd_stat(8'h02);
		cmd(8'h06);
		wr_stat(8'hFF);
		rd_stat(8'h8C);
		wp_n <= 1'b0;
		cmd(8'h06);
		wr_stat(8'h00);
		rd_stat(8'h8C);
		wp_n <= 1'b1;
		cmd(8'h06);
		wr_stat(8'h00);
		rd_stat(8'h00);
		// Burst of 16 with the sink stalled, wrapping past the top
		cmd(8'h06);
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(8'h02, q);
		spfe_spi_master_inst.xfer(8'hFF, q);
		spfe_spi_master_inst.xfer(8'hF8, q);
		for (k = 0; k < 16; k = k + 1) spfe_spi_master_inst.xfer(8'h50 + k[7:0], q);
		spfe_spi_master_inst.desel;
		rd_stat(8'h00);
		drain(13'h1FF8, 8'h50, 16);
		cmd(8'h06);
		wr_stat(8'h04);
		cmd(8'h06);
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(8'h02, q);
		spfe_spi_master_inst.xfer(8'h17, q);
		spfe_spi_master_inst.xfer(8'hFF, q);
		spfe_spi_master_inst.xfer(8'h11, q);
		spfe_spi_master_inst.xfer(8'h22, q);
		spfe_spi_master_inst.desel;
		drain(13'h17FF, 8'h11, 1);
		// Memory read across the top address
		spfe_spi_master_inst.sel(1'b1);
		spfe_spi_master_inst.xfer(8'h03, q);
		spfe_spi_master_inst.xfer(8'hFF, q);
		spfe_spi_master_inst.xfer(8'hFF, q);
		spfe_spi_master_inst.xfer(8'h00, s);
		cmp_byte(s, 8'hC3);
		spfe_spi_master_inst.xfer(8'h00, s);
		cmp_byte(s, 8'h3C);
		spfe_spi_master_inst.desel;
		cmp_byte({7'h00, spfe_spi_master_inst.drove}, 8'h01);
		spfe_spi_master_inst.sel(1'b0);
		spfe_spi_master_inst.xfer(8'hAA, q);
		spfe_spi_master_inst.xfer(8'h05, q);
		spfe_spi_master_inst.xfer(8'h00, q);
		spfe_spi_master_inst.desel;
		cmp_byte({7'h00, spfe_spi_master_inst.drove}, 8'h00);
		report_and_stop;
	end
endmodule

// ### spfe_map.vh
// Constants for the serial command front end of an 8K x 8 memory.
// Assumes inclusion by the front end design and assertion files.
`ifndef SPFE_MAP_VH
`define SPFE_MAP_VH

// Command opcodes
`define SPFE_OP_SET_WRITE_LATCH 8'h06
`define SPFE_OP_CLEAR_WRITE_LATCH 8'h04
`define SPFE_OP_READ_STATUS 8'h05
`define SPFE_OP_WRITE_STATUS 8'h01
`define SPFE_OP_READ_MEM 8'h03
`define SPFE_OP_WRITE_MEM 8'h02

// Status byte layout and reset value
`define SPFE_STAT_RESET 8'h00
`define SPFE_STAT_PIN_PROTECT 7
`define SPFE_STAT_BP_HIGH 3
`define SPFE_STAT_BP_LOW 2
`define SPFE_STAT_LATCH 1

// Address space and protected ranges
`define SPFE_ADDR_W 13
`define SPFE_ADDR_TOP 13'h1FFF
`define SPFE_PROT_QUARTER 13'h1800
`define SPFE_PROT_HALF 13'h1000

// Write stream buffer
`define SPFE_FIFO_W 21
`define SPFE_FIFO_DEPTH 16
`define SPFE_FIFO_AW 4

`endif

// ### spfe_spi_master.sv
// Bus master model for the serial front end: drives select, clock, data.
// Assumes the bench CLK; half a link period is four CLK cycles (100 ns).
`timescale 1ns/1ps
module spfe_spi_master (
	input wire clk, // System clock
	input wire so, // Device serial out
	input wire so_oe_n, // Device drive enable, low active
	output reg cs_n, // Chip select, low active
	output reg sck, // Link clock
	output reg si // Device serial in
);
	reg m3_q;
	reg drove;
	// Idle lines at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		drove = 1'b0;
		m3_q = 1'b0;
	end
	task tick(input integer n);
		integer k;
		for (k = 0; k < n; k = k + 1) @(posedge clk);
	endtask
	// park clock at mode level, then select
	task sel(input m3);
		m3_q = m3;
		sck <= m3;
		tick(4);
		cs_n <= 1'b0;
		drove = 1'b0;
		tick(8);
	endtask
	// MSB first; data set at fall, reply read late in high phase
	task xfer(input [7:0] d, output [7:0] q);
		integer i;
		for (i = 7; i >= 0; i = i - 1) begin
			sck <= 1'b0;
			si <= d[i];
			tick(4);
			sck <= 1'b1;
			tick(4);
			q[i] = so;
			if (so_oe_n === 1'b0) drove = 1'b1;
		end
	endtask
	// park clock, deselect, and stop showing the last bit
	task desel;
		if (!m3_q) sck <= 1'b0;
		tick(4);
		cs_n <= 1'b1;
		si <= ~si;
		tick(8);
	endtask
endmodule
